// [register_command_and_port_ctrl.sv]
/*
 Register command interpreter and general-purpose output port for one axis.
 Assumes host writes are single-cycle strobes synchronous to clk and that the
 host keeps the documented spacing or honours wait_request_n.
*/
`timescale 1ns/1ps
module register_command_and_port_ctrl
(
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire regcmd_pkg::host_write_t host_wr,
	input  wire logic [1:0]              buf_rd_sel,
	output logic [7:0]                   buf_rd_data,
	input  wire regcmd_pkg::ro_regs_t    ro_regs,
	input  wire logic                    axis_running,
	input  wire logic [7:0]              pin_dir_out,
	input  wire logic [7:0]              general_purpose_pins_in,
	output logic [7:0]                   general_purpose_pins_out,
	output logic [7:0]                   general_purpose_pins_oe,
	output logic                         wait_request_n,
	output logic [31:0]                  work_regs [regcmd_pkg::NUM_RW],
	output logic [31:0]                  pre_regs [regcmd_pkg::NUM_PRE+2],
	output logic [7:0]                   pre_pending
);
	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic        cmd_wr;
	logic        port_wr;
	logic [7:0]  cmd;
	logic [31:0] io_buf_ff;
	logic [7:0]  port_ff;
	logic [2:0]  busy_ff;
	logic [12:0] pend_ff;
	logic [31:0] rd_word;
	logic        rd_hit;

	assign cmd     = host_wr.data;
	assign cmd_wr  = host_wr.wr && (host_wr.addr == regcmd_pkg::ADDR_COMMAND);
	assign port_wr = host_wr.wr && (host_wr.addr == regcmd_pkg::ADDR_OUTPUT_PORT);

	// Read source selection
	always_comb
	begin
		rd_word = regcmd_pkg::WORD_RESET;
		rd_hit  = 1'b1;
		if (cmd >= regcmd_pkg::CMD_RD_BASE && cmd <= regcmd_pkg::CMD_RD_LAST)
		begin
			if (cmd == regcmd_pkg::CMD_RD_CMP5)
				rd_word = work_regs[regcmd_pkg::SLOT_CMP5];
			else if (cmd == regcmd_pkg::CMD_RD_LAST)
				rd_word = work_regs[regcmd_pkg::NUM_WORK - 1];
			else
				rd_word = work_regs[5'(cmd - regcmd_pkg::CMD_RD_BASE)];
		end
		else if (cmd >= regcmd_pkg::CMD_RD_PRE_BASE && cmd <= regcmd_pkg::CMD_RD_PRE_LAST)
			rd_word = pre_regs[4'(cmd - regcmd_pkg::CMD_RD_PRE_BASE)];
		else if (cmd == regcmd_pkg::CMD_RD_PCP5)
			rd_word = pre_regs[regcmd_pkg::NUM_PRE];
		else if (cmd == regcmd_pkg::CMD_RD_PRE_CI)
			rd_word = pre_regs[regcmd_pkg::NUM_PRE + 1];
		else
		begin
			case (cmd)
				regcmd_pkg::CMD_RD_LTC_BASE:       rd_word = ro_regs.latch1;
				regcmd_pkg::CMD_RD_LTC_BASE + 8'h01: rd_word = ro_regs.latch2;
				regcmd_pkg::CMD_RD_LTC_BASE + 8'h02: rd_word = ro_regs.latch3;
				regcmd_pkg::CMD_RD_LTC_LAST:       rd_word = ro_regs.latch4;
				regcmd_pkg::CMD_RD_EXT_STS:        rd_word = ro_regs.ext_sts;
				regcmd_pkg::CMD_RD_ERR_STS:        rd_word = work_regs[regcmd_pkg::SLOT_ERR_STS];
				regcmd_pkg::CMD_RD_EVT_STS:        rd_word = work_regs[regcmd_pkg::SLOT_EVT_STS];
				regcmd_pkg::CMD_RD_RESIDUAL:       rd_word = ro_regs.residual;
				regcmd_pkg::CMD_RD_SPEED:          rd_word = ro_regs.speed;
				regcmd_pkg::CMD_RD_RAMPDOWN:       rd_word = ro_regs.rampdown;
				regcmd_pkg::CMD_RD_CI:             rd_word = work_regs[regcmd_pkg::SLOT_CI];
				regcmd_pkg::CMD_RD_CIC:            rd_word = ro_regs.cic;
				regcmd_pkg::CMD_RD_IPS:            rd_word = ro_regs.ips;
				default:                           rd_hit  = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// I/O buffer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			io_buf_ff <= regcmd_pkg::WORD_RESET;
		else if (cmd_wr && rd_hit)
			io_buf_ff <= rd_word;
		else if (host_wr.wr && host_wr.addr[2])
		begin
			case (host_wr.addr[1:0])
				2'h0:    io_buf_ff[7:0]   <= host_wr.data;
				2'h1:    io_buf_ff[15:8]  <= host_wr.data;
				2'h2:    io_buf_ff[23:16] <= host_wr.data;
				default: io_buf_ff[31:24] <= host_wr.data;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			buf_rd_data <= 8'h00;
		else
			buf_rd_data <= io_buf_ff[8*buf_rd_sel +: 8];
	end

	// ----------------------------------------------------------------
	// Working and pre registers
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < regcmd_pkg::NUM_RW; gi++)
		begin : g_work
			logic wr_hit;
			logic pre_move;
			always_comb
			begin
				wr_hit   = 1'b0;
				pre_move = 1'b0;
				if (gi < regcmd_pkg::NUM_WORK)
					wr_hit = cmd_wr && (cmd == regcmd_pkg::CMD_WR_BASE + 8'(gi));
				else if (gi == regcmd_pkg::SLOT_ERR_STS)
					wr_hit = cmd_wr && (cmd == regcmd_pkg::CMD_WR_ERR_STS);
				else if (gi == regcmd_pkg::SLOT_EVT_STS)
					wr_hit = cmd_wr && (cmd == regcmd_pkg::CMD_WR_EVT_STS);
				else
					wr_hit = cmd_wr && (cmd == regcmd_pkg::CMD_WR_CI);
				if (gi < regcmd_pkg::NUM_PRE)
					pre_move = pend_ff[gi] && !axis_running;
				else if (gi == regcmd_pkg::SLOT_CMP5)
					pre_move = pend_ff[regcmd_pkg::NUM_PRE] && !axis_running;
				else if (gi == regcmd_pkg::SLOT_CI)
					pre_move = pend_ff[regcmd_pkg::NUM_PRE + 1] && !axis_running;
			end
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					work_regs[gi] <= regcmd_pkg::WORD_RESET;
				else if (wr_hit)
					work_regs[gi] <= io_buf_ff;
				else if (pre_move)
				begin
					if (gi == regcmd_pkg::SLOT_CMP5)
						work_regs[gi] <= pre_regs[regcmd_pkg::NUM_PRE];
					else if (gi == regcmd_pkg::SLOT_CI)
						work_regs[gi] <= pre_regs[regcmd_pkg::NUM_PRE + 1];
					else
						work_regs[gi] <= pre_regs[gi % regcmd_pkg::NUM_PRE];
				end
			end
		end
		for (gi = 0; gi < regcmd_pkg::NUM_PRE + 2; gi++)
		begin : g_pre
			logic [7:0] code;
			assign code = (gi < regcmd_pkg::NUM_PRE) ? regcmd_pkg::CMD_WR_PRE_BASE + 8'(gi)
				: (gi == regcmd_pkg::NUM_PRE) ? regcmd_pkg::CMD_WR_PCP5
				: regcmd_pkg::CMD_WR_PRE_CI;
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					pre_regs[gi] <= regcmd_pkg::WORD_RESET;
					pend_ff[gi]  <= 1'b0;
				end
				else if (cmd_wr && cmd == code)
				begin
					pre_regs[gi] <= io_buf_ff;
					pend_ff[gi]  <= 1'b1;
				end
				else if (!axis_running)
					pend_ff[gi] <= 1'b0;
			end
		end
	endgenerate

	assign pre_pending = pend_ff[7:0];

	// ----------------------------------------------------------------
	// General-purpose output port
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			port_ff <= regcmd_pkg::PORT_RESET;
		else if (port_wr)
			port_ff <= host_wr.data;
		else if (cmd_wr && cmd >= regcmd_pkg::CMD_BIT_RST_BASE
			&& cmd <= regcmd_pkg::CMD_BIT_LAST)
			port_ff[cmd[2:0]] <= cmd[3];
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			general_purpose_pins_out <= regcmd_pkg::PORT_RESET;
		else
			general_purpose_pins_out <= port_ff;
	end

	assign general_purpose_pins_oe = pin_dir_out;

	// ----------------------------------------------------------------
	// Wait request
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			busy_ff <= 3'h0;
		else if (port_wr)
			busy_ff <= regcmd_pkg::BUSY_CNT;
		else if (busy_ff != 3'h0)
			busy_ff <= busy_ff - 3'h1;
	end

	assign wait_request_n = !(port_wr || busy_ff != 3'h0);

endmodule // register_command_and_port_ctrl

// [regcmd_pkg.sv]
/*
 Package for the register command interpreter: command codes, port offsets,
 register slot indices, timing counts and the carrier structs.
 Assumes a single 250 MHz clock domain and an 8-bit host data path.
*/
// Behaviour
// - Eleven motion registers: read D0h-DAh, write 90h-9Ah; pre copies C0h-CAh, 80h-8Ah.
// - Correction speed register reads with DBh, writes with 9Bh, no pre copy.
// - Environment, counters, event setting: read DCh-E6h, ECh; write 9Ch-A6h, ACh.
// - Comparator one to four data: read E7h-EAh, write A7h-AAh, no pre copy.
// - Comparator five writes ABh; its pre copy reads CBh, writes 8Bh.
// - Speed monitor register is read only with code F5h.
// - Writing the output port command updates the eight port pin levels.
// - A pin is driven only while its direction setting selects output.
// - On word writes to the output port only the low byte acts.
// - Commanded pin levels stay latched while a pin is set to input.
// - A bit control command sets or clears one pin level alone.
// - Wait request is asserted low while a port command is processed.
// - Register reads copy into the I/O buffer, writes copy the buffer out.
// - Pre data moves to working registers when stopped, else stays held.
package regcmd_pkg;
	// ----------------------------------------------------------------
	// Host port offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] ADDR_COMMAND     = 3'h0;
	localparam logic [2:0] ADDR_OUTPUT_PORT = 3'h2;
	localparam logic [2:0] ADDR_BUF_BASE    = 3'h4;
	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_WR_PRE_BASE  = 8'h80;
	localparam logic [7:0] CMD_WR_PRE_LAST  = 8'h8A;
	localparam logic [7:0] CMD_WR_PCP5      = 8'h8B;
	localparam logic [7:0] CMD_WR_PRE_CI    = 8'h8C;
	localparam logic [7:0] CMD_WR_BASE      = 8'h90;
	localparam logic [7:0] CMD_WR_LAST      = 8'hAC;
	localparam logic [7:0] CMD_WR_ERR_STS   = 8'hB2;
	localparam logic [7:0] CMD_WR_EVT_STS   = 8'hB3;
	localparam logic [7:0] CMD_WR_CI        = 8'hBC;
	localparam logic [7:0] CMD_RD_PRE_BASE  = 8'hC0;
	localparam logic [7:0] CMD_RD_PRE_LAST  = 8'hCA;
	localparam logic [7:0] CMD_RD_PCP5      = 8'hCB;
	localparam logic [7:0] CMD_RD_PRE_CI    = 8'hCC;
	localparam logic [7:0] CMD_RD_BASE      = 8'hD0;
	localparam logic [7:0] CMD_RD_LAST      = 8'hEC;
	localparam logic [7:0] CMD_RD_CMP5      = 8'hEB;
	localparam logic [7:0] CMD_RD_LTC_BASE  = 8'hED;
	localparam logic [7:0] CMD_RD_LTC_LAST  = 8'hF0;
	localparam logic [7:0] CMD_RD_EXT_STS   = 8'hF1;
	localparam logic [7:0] CMD_RD_ERR_STS   = 8'hF2;
	localparam logic [7:0] CMD_RD_EVT_STS   = 8'hF3;
	localparam logic [7:0] CMD_RD_RESIDUAL  = 8'hF4;
	localparam logic [7:0] CMD_RD_SPEED     = 8'hF5;
	localparam logic [7:0] CMD_RD_RAMPDOWN  = 8'hF6;
	localparam logic [7:0] CMD_RD_CI        = 8'hFC;
	localparam logic [7:0] CMD_RD_CIC       = 8'hFD;
	localparam logic [7:0] CMD_RD_IPS       = 8'hFF;
	// Bit control: 10h-17h clear pin n, 18h-1Fh set pin n
	localparam logic [7:0] CMD_BIT_RST_BASE = 8'h10;
	localparam logic [7:0] CMD_BIT_SET_BASE = 8'h18;
	localparam logic [7:0] CMD_BIT_LAST     = 8'h1F;
	// ----------------------------------------------------------------
	// Register slots
	// ----------------------------------------------------------------
	localparam int NUM_WORK      = 29;
	localparam int NUM_PRE       = 11;
	localparam int SLOT_CMP5     = 27;
	localparam int SLOT_ERR_STS  = 29;
	localparam int SLOT_EVT_STS  = 30;
	localparam int SLOT_CI       = 31;
	localparam int NUM_RW        = 32;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [7:0]  PORT_RESET = 8'h00;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 4;
	localparam int PORT_WAIT_CLKS = 4;
	localparam int READ_WAIT_CLKS = 4;
	localparam logic [2:0] BUSY_CNT = 3'(PORT_WAIT_CLKS - 1);
	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic [2:0] addr;
		logic [7:0] data;
		logic [7:0] data_hi;
	} host_write_t;
	typedef struct packed {
		logic [31:0] latch1;
		logic [31:0] latch2;
		logic [31:0] latch3;
		logic [31:0] latch4;
		logic [31:0] ext_sts;
		logic [31:0] residual;
		logic [31:0] speed;
		logic [31:0] rampdown;
		logic [31:0] cic;
		logic [31:0] ips;
	} ro_regs_t;
endpackage

// [regcmd_asserts.sv]
/*
 Checker for the register command interpreter and output port.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module regcmd_asserts
(
	input wire logic                    clk,
	input wire logic                    arst_n,
	input wire regcmd_pkg::host_write_t host_wr,
	input wire logic                    axis_running,
	input wire logic [7:0]              pin_dir_out,
	input wire logic [7:0]              general_purpose_pins_out,
	input wire logic [7:0]              general_purpose_pins_oe,
	input wire logic                    wait_request_n,
	input wire logic [31:0]             work_regs [regcmd_pkg::NUM_RW],
	input wire logic [31:0]             pre_regs [regcmd_pkg::NUM_PRE+2],
	input wire logic [7:0]              pre_pending
);
	// ----------------------------------------------------------------
	// Shadow of the I/O buffer
	// ----------------------------------------------------------------
	logic [31:0] buf_ff;
	wire         cmd_w  = host_wr.wr && host_wr.addr == regcmd_pkg::ADDR_COMMAND;
	wire         port_w = host_wr.wr && host_wr.addr == regcmd_pkg::ADDR_OUTPUT_PORT;
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			buf_ff <= 32'h0000_0000;
		else if (host_wr.wr && host_wr.addr[2])
			buf_ff[8*host_wr.addr[1:0] +: 8] <= host_wr.data;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_WRQ_LOW:
		assert property (port_w |-> !wait_request_n [*4]) else $error("wait request short");
	AST_PORT_PINS:
		assert property (port_w |-> ##2 general_purpose_pins_out == $past(host_wr.data, 2))
		else $error("port levels wrong");
	AST_PIN_OE:
		assert property (general_purpose_pins_oe == pin_dir_out) else $error("pin enable wrong");
	AST_PIN_LATCH:
		assert property ($changed(general_purpose_pins_out) |-> $past(cmd_w) || $past(cmd_w, 2)
			|| $past(port_w, 2)) else $error("pin levels changed unasked");
	AST_WORK_WR:
		assert property (cmd_w && host_wr.data inside {[8'h90:8'hAC]} |=>
			work_regs[$past(host_wr.data) - 8'h90] == $past(buf_ff)) else $error("work write");
	AST_PRE_WR:
		assert property (cmd_w && host_wr.data inside {[8'h80:8'h8C]} |=>
			pre_regs[$past(host_wr.data) - 8'h80] == $past(buf_ff)) else $error("pre write");
	AST_PRE_MOVE:
		assert property (pre_pending[0] && !axis_running && !host_wr.wr |=>
			work_regs[0] == $past(pre_regs[0])) else $error("pre data not moved");
	AST_PRE_HOLD:
		assert property (axis_running && !host_wr.wr |=> $stable(work_regs[0]))
		else $error("work changed while running");
	AST_BIT_SET:
		assert property (cmd_w && host_wr.data == 8'h19 |-> ##[1:2] general_purpose_pins_out[1])
		else $error("bit set missed");
endmodule // regcmd_asserts
bind register_command_and_port_ctrl regcmd_asserts i_chk (.clk, .arst_n, .host_wr,
	.axis_running, .pin_dir_out, .general_purpose_pins_out, .general_purpose_pins_oe,
	.wait_request_n, .work_regs, .pre_regs, .pre_pending);

// [host_cpu_model.sv]
/*
 Host CPU model: single-cycle write strobes and buffer byte reads.
 Assumes the device samples strobes on the rising clock edge.
*/
`timescale 1ns/1ps
module host_cpu_model
(
	input  wire logic               clk,
	input  wire logic               wait_request_n,
	input  wire logic [7:0]         buf_rd_data,
	output regcmd_pkg::host_write_t host_wr,
	output logic [1:0]              buf_rd_sel
);
	int n_stall = 0;
	initial
	begin
		host_wr = '0;
		buf_rd_sel = 2'h0;
	end
	task automatic wr_byte(input logic [2:0] a, input logic [7:0] d, input logic [7:0] hi = 8'h00);
		@(negedge clk);
		host_wr = '{wr: 1'b1, addr: a, data: d, data_hi: hi};
		@(negedge clk);
		host_wr = '{wr: 1'b0, addr: ~a, data: ~d, data_hi: ~hi};
		for (int i = 0; i < 8 && !wait_request_n; i++)
			@(negedge clk);
		if (!wait_request_n)
			n_stall++;
		@(negedge clk);
	endtask
	task automatic wr_word(input logic [31:0] w);
		for (int k = 0; k < 4; k++)
			wr_byte(3'h4 + 3'(k), w[8*k +: 8]);
	endtask
	task automatic rd_reg(input logic [7:0] c, output logic [31:0] w);
		wr_byte(3'h0, c);
		repeat (4) @(negedge clk);
		for (int k = 0; k < 4; k++)
		begin
			@(negedge clk);
			buf_rd_sel = 2'(k);
			@(negedge clk);
			w[8*k +: 8] = buf_rd_data;
		end
	endtask
endmodule // host_cpu_model

// [register_command_and_port_ctrl_tb.sv]
/*
 Testbench: register transfers, pre data, read-only codes and the port.
 Assumes the host model and the checker are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module register_command_and_port_ctrl_tb;
	logic                    clk = 1'b0;
	logic                    arst_n = 1'b0;
	logic                    axis_running = 1'b0;
	logic [7:0]              pin_dir_out = 8'h00;
	regcmd_pkg::host_write_t host_wr;
	regcmd_pkg::ro_regs_t    ro_regs;
	logic [1:0]              buf_rd_sel;
	logic [7:0]              buf_rd_data, pins_out, pins_oe, pending;
	logic                    wait_request_n;
	logic [31:0]             work_regs [regcmd_pkg::NUM_RW];
	logic [31:0]             pre_regs [regcmd_pkg::NUM_PRE+2];
	logic [31:0]             rd_w, val;
	logic [7:0]              st_cmd [3] = '{8'hB2, 8'hB3, 8'hBC};
	int                      n_fail = 0;
	int                      compares = 0;
	host_cpu_model i_host (.clk, .wait_request_n, .buf_rd_data, .host_wr, .buf_rd_sel);
	register_command_and_port_ctrl i_dut (.clk, .arst_n, .host_wr, .buf_rd_sel, .buf_rd_data,
		.ro_regs, .axis_running, .pin_dir_out, .general_purpose_pins_in(8'h00),
		.general_purpose_pins_out(pins_out), .general_purpose_pins_oe(pins_oe),
		.wait_request_n, .work_regs, .pre_regs, .pre_pending(pending));
	initial
		forever #2 clk = ~clk;
	task automatic wrap_up;
		`CHK("stalls", 0, i_host.n_stall)
		$display("compares %0d fails %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		for (int i = 0; i < 10; i++)
			ro_regs[32*i +: 32] = {4{8'(i + 1)}};
		repeat (8) @(negedge clk);
		arst_n = 1'b1;
		`CHK("pins reset", 8'h00, pins_out)
		`CHK("wrq reset", 1'b1, wait_request_n)
		for (int k = 0; k < regcmd_pkg::NUM_WORK; k++)
		begin
			val = 32'hC3A5_0000 | 32'(k);
			i_host.wr_word(val);
			i_host.wr_byte(3'h0, 8'h90 + 8'(k));
			`CHK("work", val, work_regs[k])
			i_host.rd_reg(8'hD0 + 8'(k), rd_w);
			`CHK("work read", val, rd_w)
		end
		$display("test working registers done");
		axis_running = 1'b1;
		for (int k = 0; k < regcmd_pkg::NUM_PRE + 2; k++)
		begin
			val = 32'h5A00_0000 | 32'(k);
			i_host.wr_word(val);
			i_host.wr_byte(3'h0, 8'h80 + 8'(k));
			`CHK("pre", val, pre_regs[k])
			i_host.rd_reg(8'hC0 + 8'(k), rd_w);
			`CHK("pre read", val, rd_w)
		end
		`CHK("held", 32'hC3A5_0000, work_regs[0])
		axis_running = 1'b0;
		repeat (2) @(negedge clk);
		`CHK("moved", 32'h5A00_0000, work_regs[0])
		$display("test pre registers done");
		i_host.rd_reg(8'hF5, rd_w);
		`CHK("speed", ro_regs.speed, rd_w)
		i_host.rd_reg(8'hED, rd_w);
		`CHK("latch", ro_regs.latch1, rd_w)
		i_host.wr_word(32'h0000_BEEF);
		i_host.wr_byte(3'h0, 8'hF5);
		`CHK("ro write", 32'h5A00_0000, work_regs[0])
		for (int k = 0; k < 3; k++)
		begin
			i_host.wr_byte(3'h0, st_cmd[k]);
			`CHK("status", ro_regs.speed, work_regs[29 + k])
		end
		$display("test read-only codes done");
		pin_dir_out = 8'h0F;
		i_host.wr_byte(3'h2, 8'h55, 8'hAA);
		`CHK("port", 8'h55, pins_out)
		`CHK("oe", 8'h0F, pins_oe)
		pin_dir_out = 8'h00;
		i_host.wr_byte(3'h0, 8'h19);
		`CHK("bit set", 8'h57, pins_out)
		i_host.wr_byte(3'h0, 8'h10);
		`CHK("bit clear", 8'h56, pins_out)
		`CHK("oe input", 8'h00, pins_oe)
		$display("test output port done");
		wrap_up();
	end
endmodule // register_command_and_port_ctrl_tb
